// [rtl/dual_clock_queue.v]
// Dual clock queue: writer and reader clocks sampled on clk_sys, bit storage and flags.
// Assumes both user clocks are much slower than clk_sys and inputs are held around edges.
`timescale 1ns/100ps
`default_nettype none
`include "dual_clock_queue_defines.vh"

// Notes on behaviour
// - Writes happen only on write clock edges.
// - Large capacity cascades blocks; small uses one.
// - Reset clears registers, never the stored words.
// - Write width 1 to 36, default 18.
// - Read width independent, default 18.
// - Two bit select decodes gate each side.
// - Four high active flags: empty to full.
// - Almost thresholds are 14 bit settings.
// - Degenerate almost levels fall back to empty/full.
// - After reset empty and almost empty high.
// - Thresholds are absolute word counts.
// - Empty flags registered on read clock.
// - Full flags registered on write clock.
// - Reset holds both pointers at zero.
// - Write enable stores word at write pointer.
// - Global set/reset participation selectable, default on.
// - Read enable delivers word at read pointer.
// - Internal read gated by registered not empty.
// - First word after two reads, buffered three.
// - Reset returns pointers and flags to start.
module dual_clock_queue #(
  parameter WRITE_WIDTH = `DEFAULT_WIDTH,
  parameter READ_WIDTH = `DEFAULT_WIDTH,
  parameter DEPTH_BLOCKS = `DEFAULT_BLOCKS,
  parameter OUTPUT_STAGE_SELECT = `UNBUFFERED_OUTPUT,
  parameter INIT_STYLE = `INIT_ASYNC,
  parameter [`SELECT_W-1:0] WRITE_SELECT_MATCH = `SELECT_MATCH_DEFAULT,
  parameter [`SELECT_W-1:0] READ_SELECT_MATCH = `SELECT_MATCH_DEFAULT,
  parameter GSR_ENABLE = `GSR_ENABLED
) (
  // System clock and resets.
  input wire clk_sys,
  input wire rst,
  input wire global_set_reset,
  // Writer side pins.
  input wire write_clock,
  input wire write_enable,
  input wire [`SELECT_W-1:0] write_select,
  input wire [WRITE_WIDTH-1:0] data_in,
  input wire [`LEVEL_W-1:0] almost_full_level,
  // Reader side pins.
  input wire read_clock,
  input wire fetch_enable,
  input wire [`SELECT_W-1:0] read_select,
  input wire [`LEVEL_W-1:0] almost_empty_level,
  // Data and flags.
  output wire [READ_WIDTH-1:0] data_out,
  output wire empty_flag,
  output wire almost_empty_flag,
  output wire almost_full_flag,
  output wire full_flag
);

  // Storage size in bits, one block per nine bit family or binary family.
  localparam BLOCK_BITS = (((WRITE_WIDTH % `NINE_FAMILY) == 0) &&
    ((READ_WIDTH % `NINE_FAMILY) == 0)) ? `BLOCK_BITS_WIDE : `BLOCK_BITS_NARROW;
  localparam CAP = BLOCK_BITS * DEPTH_BLOCKS;
  localparam [`MATH_W-1:0] CAP_M = CAP;
  localparam [`MATH_W-1:0] WW_M = WRITE_WIDTH;
  localparam [`MATH_W-1:0] RW_M = READ_WIDTH;
  localparam [`MATH_W-1:0] FULL_LEVEL_M = CAP / WRITE_WIDTH;
  localparam [`PTR_W-1:0] WW_P = WRITE_WIDTH;
  localparam [`PTR_W-1:0] RW_P = READ_WIDTH;
  localparam [`PTR_W-1:0] CAP_P = CAP;
  localparam [`CNT_W-1:0] WW_C = WRITE_WIDTH;
  localparam [`CNT_W-1:0] RW_C = READ_WIDTH;
  localparam WG = WRITE_WIDTH + `SELECT_W + `LEVEL_W + 2;
  localparam RG = `SELECT_W + `LEVEL_W + 2;

  // Reset request and its routing by style.
  wire reset_req;
  wire arst;
  wire srst;

  assign reset_req = rst | ((GSR_ENABLE == `GSR_ENABLED) & global_set_reset);
  assign arst = (INIT_STYLE == `INIT_ASYNC) & reset_req;
  assign srst = (INIT_STYLE == `INIT_SYNC) & reset_req;

  // Synchronised pin groups.
  wire [WG-1:0] wgrp_mid;
  wire [WG-1:0] wgrp_late;
  wire [RG-1:0] rgrp_mid;
  wire [RG-1:0] rgrp_late;

  sync3 #(
    .W(WG)
  ) u_write_sync (
    .clk_sys(clk_sys),
    .arst(arst),
    .srst(srst),
    .d({write_clock, write_enable, write_select, almost_full_level, data_in}),
    .mid(wgrp_mid),
    .late(wgrp_late)
  );

  sync3 #(
    .W(RG)
  ) u_read_sync (
    .clk_sys(clk_sys),
    .arst(arst),
    .srst(srst),
    .d({read_clock, fetch_enable, read_select, almost_empty_level}),
    .mid(rgrp_mid),
    .late(rgrp_late)
  );

  // Unpacked synchronised signals.
  wire wclk_mid;
  wire wclk_late;
  wire wen_s;
  wire [`SELECT_W-1:0] wsel_s;
  wire [`LEVEL_W-1:0] af_level_s;
  wire [WRITE_WIDTH-1:0] wdata_s;
  wire rclk_mid;
  wire rclk_late;
  wire ren_s;
  wire [`SELECT_W-1:0] rsel_s;
  wire [`LEVEL_W-1:0] ae_level_s;

  assign wclk_mid = wgrp_mid[WG-1];
  assign wclk_late = wgrp_late[WG-1];
  assign wen_s = wgrp_late[WG-2];
  assign wsel_s = wgrp_late[WG-3:WG-2-`SELECT_W];
  assign af_level_s = wgrp_late[WRITE_WIDTH+`LEVEL_W-1:WRITE_WIDTH];
  assign wdata_s = wgrp_late[WRITE_WIDTH-1:0];
  assign rclk_mid = rgrp_mid[RG-1];
  assign rclk_late = rgrp_late[RG-1];
  assign ren_s = rgrp_late[RG-2];
  assign rsel_s = rgrp_late[RG-3:RG-2-`SELECT_W];
  assign ae_level_s = rgrp_late[`LEVEL_W-1:0];

  // A level word is taken only once two stages agree, so a word in flight is never used.
  reg [`LEVEL_W-1:0] af_level_q;
  reg [`LEVEL_W-1:0] ae_level_q;
  wire [`LEVEL_W-1:0] af_level_mid;
  wire [`LEVEL_W-1:0] ae_level_mid;

  assign af_level_mid = wgrp_mid[WRITE_WIDTH+`LEVEL_W-1:WRITE_WIDTH];
  assign ae_level_mid = rgrp_mid[`LEVEL_W-1:0];

  always @(posedge clk_sys or posedge arst) begin
    if (arst) begin
      af_level_q <= `EMPTY_LEVEL;
      ae_level_q <= `EMPTY_LEVEL;
    end else if (srst) begin
      af_level_q <= `EMPTY_LEVEL;
      ae_level_q <= `EMPTY_LEVEL;
    end else begin
      if (af_level_mid == af_level_s) begin
        af_level_q <= af_level_s;
      end
      if (ae_level_mid == ae_level_s) begin
        ae_level_q <= ae_level_s;
      end
    end
  end

  // Filtered clock levels and their rising edge events.
  reg wclk_f_q;
  reg rclk_f_q;
  wire write_event;
  wire read_event;

  assign write_event = (wclk_mid == wclk_late) & wclk_late & ~wclk_f_q;
  assign read_event = (rclk_mid == rclk_late) & rclk_late & ~rclk_f_q;

  always @(posedge clk_sys or posedge arst) begin
    if (arst) begin
      wclk_f_q <= 1'b0;
      rclk_f_q <= 1'b0;
    end else if (srst) begin
      wclk_f_q <= 1'b0;
      rclk_f_q <= 1'b0;
    end else begin
      if (wclk_mid == wclk_late) begin
        wclk_f_q <= wclk_late;
      end
      if (rclk_mid == rclk_late) begin
        rclk_f_q <= rclk_late;
      end
    end
  end

  // State registers.
  reg [`PTR_W-1:0] wptr_q;
  reg [`PTR_W-1:0] wptr_d;
  reg [`PTR_W-1:0] rptr_q;
  reg [`PTR_W-1:0] rptr_d;
  reg [`CNT_W-1:0] cnt_q;
  reg [`CNT_W-1:0] cnt_d;
  reg empty_q;
  reg almost_empty_q;
  reg full_q;
  reg almost_full_q;
  reg [READ_WIDTH-1:0] stage_q;
  reg [READ_WIDTH-1:0] data_out_q;

  // Strobes into the storage.
  wire wsel_ok;
  wire rsel_ok;
  wire write_go;
  wire read_go;
  wire read_take;
  wire [READ_WIDTH-1:0] read_data;

  assign wsel_ok = (wsel_s == WRITE_SELECT_MATCH);
  assign rsel_ok = (rsel_s == READ_SELECT_MATCH);
  assign write_go = write_event & wen_s & wsel_ok & ~full_q;
  assign read_take = read_event & ren_s & rsel_ok;
  assign read_go = read_take & ~empty_q;

  queue_storage #(
    .WW(WRITE_WIDTH),
    .RW(READ_WIDTH),
    .CAP(CAP)
  ) u_storage (
    .clk_sys(clk_sys),
    .write_strobe(write_go),
    .write_addr(wptr_q),
    .write_data(wdata_s),
    .read_addr(rptr_q),
    .read_data(read_data)
  );

  // Next pointers and occupancy in bits.
  always @* begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d = cnt_q;
    if (write_go) begin
      wptr_d = ((wptr_q + WW_P) >= CAP_P) ? {`PTR_W{1'b0}} : (wptr_q + WW_P);
      cnt_d = cnt_d + WW_C;
    end
    if (read_go) begin
      rptr_d = ((rptr_q + RW_P) >= CAP_P) ? {`PTR_W{1'b0}} : (rptr_q + RW_P);
      cnt_d = cnt_d - RW_C;
    end
  end

  // Flag thresholds as absolute word counts, scaled to bits.
  wire [`MATH_W-1:0] cnt_m;
  wire [`MATH_W-1:0] ae_m;
  wire [`MATH_W-1:0] af_m;
  wire ae_degenerate;
  wire af_degenerate;
  wire empty_d;
  wire full_d;
  wire almost_empty_d;
  wire almost_full_d;

  assign cnt_m = {{(`MATH_W-`CNT_W){1'b0}}, cnt_d};
  assign ae_m = {{(`MATH_W-`LEVEL_W){1'b0}}, ae_level_q};
  assign af_m = {{(`MATH_W-`LEVEL_W){1'b0}}, af_level_q};
  assign ae_degenerate = (ae_level_q == `EMPTY_LEVEL);
  assign af_degenerate = (af_m >= FULL_LEVEL_M);
  assign empty_d = (cnt_m < RW_M);
  assign full_d = ((cnt_m + WW_M) > CAP_M);
  // Almost empty while the words held do not pass the level.
  assign almost_empty_d = ae_degenerate ? empty_d :
    (cnt_m < ((ae_m + 24'h000001) * RW_M));
  // Almost full once the words held reach the level.
  assign almost_full_d = af_degenerate ? full_d : (cnt_m >= (af_m * WW_M));

  // Pointers and occupancy.
  always @(posedge clk_sys or posedge arst) begin
    if (arst) begin
      wptr_q <= {`PTR_W{1'b0}};
      rptr_q <= {`PTR_W{1'b0}};
      cnt_q <= {`CNT_W{1'b0}};
    end else if (srst) begin
      wptr_q <= {`PTR_W{1'b0}};
      rptr_q <= {`PTR_W{1'b0}};
      cnt_q <= {`CNT_W{1'b0}};
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
    end
  end

  // Empty side flags move only on read clock edges.
  always @(posedge clk_sys or posedge arst) begin
    if (arst) begin
      empty_q <= `EMPTY_RESET;
      almost_empty_q <= `ALMOST_EMPTY_RESET;
    end else if (srst) begin
      empty_q <= `EMPTY_RESET;
      almost_empty_q <= `ALMOST_EMPTY_RESET;
    end else if (read_event) begin
      empty_q <= empty_d;
      almost_empty_q <= almost_empty_d;
    end
  end

  // Full side flags move only on write clock edges.
  always @(posedge clk_sys or posedge arst) begin
    if (arst) begin
      full_q <= `FULL_RESET;
      almost_full_q <= `ALMOST_FULL_RESET;
    end else if (srst) begin
      full_q <= `FULL_RESET;
      almost_full_q <= `ALMOST_FULL_RESET;
    end else if (write_event) begin
      full_q <= full_d;
      almost_full_q <= almost_full_d;
    end
  end

  // Read data path; the buffered stage adds one read clock of latency.
  always @(posedge clk_sys or posedge arst) begin
    if (arst) begin
      stage_q <= {READ_WIDTH{1'b0}};
      data_out_q <= {READ_WIDTH{1'b0}};
    end else if (srst) begin
      stage_q <= {READ_WIDTH{1'b0}};
      data_out_q <= {READ_WIDTH{1'b0}};
    end else if (OUTPUT_STAGE_SELECT == `BUFFERED_OUTPUT) begin
      if (read_go) begin
        stage_q <= read_data;
      end
      if (read_take) begin
        data_out_q <= stage_q;
      end
    end else begin
      if (read_go) begin
        data_out_q <= read_data;
      end
    end
  end

  // Outputs.
  assign data_out = data_out_q;
  assign empty_flag = empty_q;
  assign almost_empty_flag = almost_empty_q;
  assign almost_full_flag = almost_full_q;
  assign full_flag = full_q;

endmodule
`default_nettype wire

// [rtl/dual_clock_queue_defines.vh]
// Constants shared by the dual clock queue, its storage and the simulation files.
// Assumes it is included by bare name from files under rtl/.
`ifndef DUAL_CLOCK_QUEUE_DEFINES_VH
`define DUAL_CLOCK_QUEUE_DEFINES_VH

// Pointer, count and arithmetic widths.
`define PTR_W 16
`define CNT_W 17
`define MATH_W 24
`define LEVEL_W 14
`define SELECT_W 2

// Word widths.
`define DEFAULT_WIDTH 18
`define MAX_WIDTH 36
`define NINE_FAMILY 9

// Storage bits in one block, for the 1/2/4 and the 9/18/36 width families.
`define BLOCK_BITS_NARROW 8192
`define BLOCK_BITS_WIDE 9216
`define DEFAULT_BLOCKS 1

// Output stage choices.
`define UNBUFFERED_OUTPUT 0
`define BUFFERED_OUTPUT 1

// Reset style choices.
`define INIT_ASYNC 0
`define INIT_SYNC 1

// Defaults of the chip select decode and of global set/reset participation.
`define SELECT_MATCH_DEFAULT 2'h0
`define GSR_ENABLED 1
`define GSR_DISABLED 0

// Empty level and the reset values of the flags.
`define EMPTY_LEVEL 14'h0000
`define EMPTY_RESET 1'b1
`define ALMOST_EMPTY_RESET 1'b1
`define FULL_RESET 1'b0
`define ALMOST_FULL_RESET 1'b0

`endif

// [rtl/sync3.v]
// Three stage synchroniser for a group of pin inputs.
// Assumes the caller reads only the second and third stages.
`timescale 1ns/100ps
`default_nettype none

module sync3 #(
  parameter W = 1
) (
  // Clock and reset.
  input wire clk_sys,
  input wire arst,
  input wire srst,
  // Raw input and the two usable stages.
  input wire [W-1:0] d,
  output wire [W-1:0] mid,
  output wire [W-1:0] late
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  always @(posedge clk_sys or posedge arst) begin
    if (arst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else if (srst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign mid = s2_q;
  assign late = s3_q;

endmodule
`default_nettype wire

// [rtl/queue_storage.v]
// Bit addressed storage array with one write port and one read port.
// Assumes word addresses are aligned to their widths and stay below CAP.
`timescale 1ns/100ps
`default_nettype none
`include "dual_clock_queue_defines.vh"

module queue_storage #(
  parameter WW = `DEFAULT_WIDTH,
  parameter RW = `DEFAULT_WIDTH,
  parameter CAP = `BLOCK_BITS_WIDE
) (
  // Clock.
  input wire clk_sys,
  // Write port.
  input wire write_strobe,
  input wire [`PTR_W-1:0] write_addr,
  input wire [WW-1:0] write_data,
  // Read port.
  input wire [`PTR_W-1:0] read_addr,
  output wire [RW-1:0] read_data
);

  reg mem [0:CAP-1];
  integer i;
  genvar g;

  // The array has no reset, so stored words survive a reset.
  always @(posedge clk_sys) begin
    if (write_strobe) begin
      for (i = 0; i < WW; i = i + 1) begin
        mem[write_addr + i] <= write_data[i];
      end
    end
  end

  // Each read bit is a plain wire from the array, so a word just written is seen at once.
  generate
    for (g = 0; g < RW; g = g + 1) begin : g_read
      assign read_data[g] = mem[read_addr + g];
    end
  endgenerate

endmodule
`default_nettype wire

// [sim/dual_clock_queue_properties.sv]
// Concurrent checks on the ports of the dual clock queue.
// Assumes user clocks held high for four or more clk_sys cycles.
`timescale 1ns/100ps
`default_nettype none
`include "dual_clock_queue_defines.vh"

module queue_properties #(
  parameter READ_WIDTH = `DEFAULT_WIDTH,
  parameter OUTPUT_STAGE_SELECT = `UNBUFFERED_OUTPUT
) (
  // Clock and resets.
  input wire clk_sys,
  input wire rst,
  input wire global_set_reset,
  // User clocks and read qualifiers.
  input wire write_clock,
  input wire read_clock,
  input wire fetch_enable,
  input wire [`SELECT_W-1:0] read_select,
  // Data and flags.
  input wire [READ_WIDTH-1:0] data_out,
  input wire empty_flag,
  input wire almost_empty_flag,
  input wire almost_full_flag,
  input wire full_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || global_set_reset);

  a_reset_flags_init: assert property ($fell(rst) |-> empty_flag && almost_empty_flag
    && !full_flag && !almost_full_flag) else $error("Flags not at reset values after reset.");
  a_empty_read_domain: assert property ($changed({empty_flag, almost_empty_flag}) |->
    $past(read_clock, 1) || $past(read_clock, 2) || $past(read_clock, 3))
    else $error("Empty side flag changed without a read clock edge.");
  a_full_write_domain: assert property ($changed({full_flag, almost_full_flag}) |->
    $past(write_clock, 1) || $past(write_clock, 2) || $past(write_clock, 3))
    else $error("Full side flag changed without a write clock edge.");
  a_out_read_edge: assert property ($changed(data_out) |->
    $past(read_clock, 1) || $past(read_clock, 2) || $past(read_clock, 3))
    else $error("Output word changed without a read clock edge.");
  a_read_qualified: assert property ($changed(data_out) |->
    $past(fetch_enable) && $past(read_select) == 2'h0)
    else $error("Output word changed without enable and select match.");
  a_no_read_empty: assert property (($changed(data_out) &&
    OUTPUT_STAGE_SELECT == `UNBUFFERED_OUTPUT) |-> !$past(empty_flag))
    else $error("Output word changed while empty was registered.");
  a_full_has_almost: assert property (full_flag |-> almost_full_flag)
    else $error("Full without almost full.");
  a_empty_has_almost: assert property (empty_flag |-> almost_empty_flag)
    else $error("Empty without almost empty.");

  c_empty_falls: cover property ($fell(empty_flag));
  c_full_rises: cover property ($rose(full_flag));
  c_almost_full_rises: cover property ($rose(almost_full_flag));
endmodule

bind dual_clock_queue queue_properties #(.READ_WIDTH(READ_WIDTH),
  .OUTPUT_STAGE_SELECT(OUTPUT_STAGE_SELECT)) u_props (
  .clk_sys(clk_sys), .rst(rst), .global_set_reset(global_set_reset),
  .write_clock(write_clock), .read_clock(read_clock), .fetch_enable(fetch_enable),
  .read_select(read_select), .data_out(data_out), .empty_flag(empty_flag),
  .almost_empty_flag(almost_empty_flag), .almost_full_flag(almost_full_flag),
  .full_flag(full_flag)
);
`default_nettype wire

// [sim/queue_user_model.sv]
// Writer and reader user logic driving the queue's user clocks and qualifiers.
// Assumes clk_sys is the queue's system clock; signals change at its falling edge.
`timescale 1ns/100ps
`default_nettype none
`include "dual_clock_queue_defines.vh"

module queue_user_model #(
  parameter W = `DEFAULT_WIDTH
) (
  // System clock.
  input wire logic clk_sys,
  // Writer side.
  output var logic write_clock,
  output var logic write_enable,
  output var logic [`SELECT_W-1:0] write_select,
  output var logic [W-1:0] data_in,
  // Reader side.
  output var logic read_clock,
  output var logic fetch_enable,
  output var logic [`SELECT_W-1:0] read_select
);
  initial begin
    write_clock = 1'b0;
    write_enable = 1'b0;
    write_select = 2'h0;
    data_in = '0;
    read_clock = 1'b0;
    fetch_enable = 1'b0;
    read_select = 2'h0;
  end

  // One write clock pulse; the clock stands low outside it and data is inverted after hold.
  task automatic push(input logic en, input logic [1:0] sel, input logic [W-1:0] d);
    @(negedge clk_sys);
    write_enable = en;
    write_select = sel;
    data_in = d;
    @(negedge clk_sys);
    write_clock = 1'b1;
    repeat (4) @(negedge clk_sys);
    write_clock = 1'b0;
    write_enable = 1'b0;
    data_in = ~d;
    repeat (4) @(negedge clk_sys);
  endtask

  // One read clock pulse with the given qualifiers.
  task automatic pull(input logic en, input logic [1:0] sel);
    @(negedge clk_sys);
    fetch_enable = en;
    read_select = sel;
    @(negedge clk_sys);
    read_clock = 1'b1;
    repeat (4) @(negedge clk_sys);
    read_clock = 1'b0;
    fetch_enable = 1'b0;
    read_select = ~sel;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [sim/dual_clock_queue_tb.sv]
// Self-checking bench: a default queue and a buffered, synchronously reset copy.
// Assumes the queue user model drives the user clocks; the bench owns resets and levels.
`timescale 1ns/100ps
`default_nettype none
`include "dual_clock_queue_defines.vh"

module dual_clock_queue_tb;
  logic clk_sys, rst, global_set_reset;
  logic [13:0] ae_level, af_level;
  logic write_clock, write_enable, read_clock, fetch_enable;
  logic [1:0] write_select, read_select;
  logic [17:0] data_in, data_out;
  logic empty_flag, almost_empty_flag, almost_full_flag, full_flag;
  logic [17:0] buf_data_out;
  logic buf_empty_flag, buf_almost_empty_flag, buf_almost_full_flag, buf_full_flag;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  queue_user_model u_user (.clk_sys(clk_sys), .write_clock(write_clock),
    .write_enable(write_enable), .write_select(write_select), .data_in(data_in),
    .read_clock(read_clock), .fetch_enable(fetch_enable), .read_select(read_select));

  dual_clock_queue dut (.clk_sys(clk_sys), .rst(rst), .global_set_reset(global_set_reset),
    .write_clock(write_clock), .write_enable(write_enable), .write_select(write_select),
    .data_in(data_in), .almost_full_level(af_level), .read_clock(read_clock),
    .fetch_enable(fetch_enable), .read_select(read_select), .almost_empty_level(ae_level),
    .data_out(data_out), .empty_flag(empty_flag), .almost_empty_flag(almost_empty_flag),
    .almost_full_flag(almost_full_flag), .full_flag(full_flag));

  dual_clock_queue #(.OUTPUT_STAGE_SELECT(`BUFFERED_OUTPUT), .INIT_STYLE(`INIT_SYNC),
    .GSR_ENABLE(`GSR_DISABLED)) dut_buf (.clk_sys(clk_sys), .rst(rst),
    .global_set_reset(global_set_reset), .write_clock(write_clock),
    .write_enable(write_enable), .write_select(write_select), .data_in(data_in),
    .almost_full_level(af_level), .read_clock(read_clock), .fetch_enable(fetch_enable),
    .read_select(read_select), .almost_empty_level(ae_level), .data_out(buf_data_out),
    .empty_flag(buf_empty_flag), .almost_empty_flag(buf_almost_empty_flag),
    .almost_full_flag(buf_almost_full_flag), .full_flag(buf_full_flag));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic flags(input logic e, input logic ae, input logic af, input logic f);
    check("empty_flag", empty_flag, e);
    check("almost_empty_flag", almost_empty_flag, ae);
    check("almost_full_flag", almost_full_flag, af);
    check("full_flag", full_flag, f);
  endtask

  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      end_sim;
    end
  end

  initial begin
    rst = 1'b1;
    global_set_reset = 1'b0;
    ae_level = 14'h0002;
    af_level = 14'h01FE;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    flags(1'b1, 1'b1, 1'b0, 1'b0);
    check("data_out", data_out, 18'h00000);
    check("buffered empty_flag", buf_empty_flag, 1'b1);
    check("buffered almost_empty_flag", buf_almost_empty_flag, 1'b1);
    check("buffered full_flag", buf_full_flag, 1'b0);
    u_user.push(1'b1, 2'h1, 18'h15555);
    u_user.push(1'b0, 2'h0, 18'h2AAAA);
    u_user.pull(1'b1, 2'h0);
    flags(1'b1, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) u_user.push(1'b1, 2'h0, 18'h2AAA0 + 18'(i));
    u_user.pull(1'b1, 2'h0);
    check("empty_flag", empty_flag, 1'b0);
    check("almost_empty_flag", almost_empty_flag, 1'b0);
    check("data_out", data_out, 18'h00000);
    u_user.pull(1'b1, 2'h0);
    check("data_out", data_out, 18'h2AAA0);
    check("buffered data_out", buf_data_out, 18'h00000);
    check("almost_empty_flag", almost_empty_flag, 1'b1);
    u_user.pull(1'b1, 2'h2);
    check("data_out", data_out, 18'h2AAA0);
    u_user.pull(1'b0, 2'h0);
    check("data_out", data_out, 18'h2AAA0);
    u_user.pull(1'b1, 2'h0);
    u_user.pull(1'b1, 2'h0);
    check("data_out", data_out, 18'h2AAA2);
    check("buffered data_out", buf_data_out, 18'h2AAA1);
    check("empty_flag", empty_flag, 1'b1);
    u_user.pull(1'b1, 2'h0);
    check("data_out", data_out, 18'h2AAA2);
    check("buffered data_out", buf_data_out, 18'h2AAA2);
    for (int i = 0; i < 512; i++) begin
      u_user.push(1'b1, 2'h0, 18'(i));
      if (i == 508) check("almost_full_flag", almost_full_flag, 1'b0);
      if (i == 509) check("almost_full_flag", almost_full_flag, 1'b1);
      if (i == 509) check("buffered almost_full_flag", buf_almost_full_flag, 1'b1);
      if (i == 510) check("full_flag", full_flag, 1'b0);
      if (i == 511) check("full_flag", full_flag, 1'b1);
    end
    u_user.push(1'b1, 2'h0, 18'h3FFFF);
    check("full_flag", full_flag, 1'b1);
    u_user.pull(1'b1, 2'h0);
    for (int i = 0; i < 512; i++) begin
      u_user.pull(1'b1, 2'h0);
      check("data_out", data_out, 18'(i));
      if (i > 0) check("buffered data_out", buf_data_out, 18'(i - 1));
    end
    check("empty_flag", empty_flag, 1'b1);
    for (int i = 0; i < 5; i++) u_user.push(1'b1, 2'h0, 18'h00F00 + 18'(i));
    global_set_reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    flags(1'b1, 1'b1, 1'b0, 1'b0);
    check("data_out", data_out, 18'h00000);
    check("buffered data_out", buf_data_out, 18'h001FE);
    global_set_reset = 1'b0;
    ae_level = 14'h0000;
    repeat (4) @(negedge clk_sys);
    u_user.push(1'b1, 2'h0, 18'h0ABCD);
    u_user.pull(1'b1, 2'h0);
    check("almost_empty_flag", almost_empty_flag, 1'b0);
    u_user.pull(1'b1, 2'h0);
    check("data_out", data_out, 18'h0ABCD);
    check("almost_empty_flag", almost_empty_flag, 1'b1);
    end_sim;
  end
endmodule
`default_nettype wire
